// file: esc_pkg.sv
// constants and types for the erase-suspend command host controller
package esc_pkg;
	localparam int ADDR_W = 26;
	localparam int DATA_W = 16;
	localparam int WC_W = 9;
	// fixed command-cycle addresses
	localparam logic [25:0] UNLOCK1_ADDR = 26'h000_0555;
	localparam logic [25:0] UNLOCK2_ADDR = 26'h000_02AA;
	// command data codes
	localparam logic [15:0] CMD_UNLOCK1 = 16'h00AA;
	localparam logic [15:0] CMD_UNLOCK2 = 16'h0055;
	localparam logic [15:0] CMD_LOCK_SET = 16'h00A0;
	localparam logic [15:0] CMD_SET_EXIT = 16'h0090;
	localparam logic [15:0] CMD_SET_EXIT2 = 16'h0000;
	localparam logic [15:0] CMD_RESET = 16'h00F0;
	localparam logic [15:0] CMD_WORD_PROG = 16'h00A0;
	localparam logic [15:0] CMD_BUF_LOAD = 16'h0025;
	localparam logic [15:0] CMD_BUF_CONFIRM = 16'h0029;
	localparam logic [15:0] CMD_SUSPEND = 16'h00B0;
	localparam logic [15:0] CMD_PSUSP_ALT = 16'h0051;
	localparam logic [15:0] CMD_RESUME = 16'h0050;
	localparam logic [15:0] CMD_RESUME_ALT = 16'h0030;
	localparam logic [15:0] CMD_SR_READ = 16'h0070;
	localparam logic [8:0] BUF_MAX_WORDS = 9'h100;
	localparam logic [2:0] STEP_CONFIRM = 3'h4;
	// timing, clock period 40 ns
	localparam int CLK_NS = 40;
	localparam int WE_LOW_NS = 60;
	localparam int READ_NS = 120;
	localparam int SYNC_CYC = 2;
	localparam int ESL_NS = 45000;
	localparam int PSL_NS = 45000;
	localparam int WE_CYC = (WE_LOW_NS + CLK_NS - 1) / CLK_NS;
	localparam int READ_CYC = (READ_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC;
	localparam int ESL_CYC = (ESL_NS + CLK_NS - 1) / CLK_NS;
	localparam int PSL_CYC = (PSL_NS + CLK_NS - 1) / CLK_NS;
	localparam int TMR_W = 11;
	// host requests
	typedef enum logic [3:0] {
		OP_LOCK_SET = 4'h0,
		OP_LOCK_EXIT = 4'h1,
		OP_RESET = 4'h2,
		OP_WORD_PROG = 4'h3,
		OP_BUF_PROG = 4'h4,
		OP_PROG_SUSP = 4'h5,
		OP_ERASE_SUSP = 4'h6,
		OP_RESUME = 4'h7,
		OP_STATUS = 4'h8
	} esc_op_t;
	// one-hot controller states
	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_SETUP = 7'h02,
		ST_STROBE = 7'h04,
		ST_HOLD = 7'h08,
		ST_DATA = 7'h10,
		ST_READ = 7'h20,
		ST_WAIT = 7'h40
	} esc_state_t;
	typedef struct packed {
		esc_state_t state;
		esc_op_t op;
		logic [2:0] step;
		logic inData;
		logic alt;
		logic unl;
		logic [25:0] addr;
		logic [15:0] wdata;
		logic [8:0] wordsLeft;
		logic [25:0] wordAddr;
		logic [10:0] timer;
		logic [25:0] busAddr;
		logic [15:0] busData;
		logic ceN;
		logic weN;
		logic oeN;
		logic dqDriveN;
		logic done;
		logic err;
		logic [15:0] rdData;
		logic [15:0] dqMeta;
		logic [15:0] dqSync;
	} esc_regs_t;
endpackage

// file: esc_host.sv
// host controller issuing erase-suspend command sequences to the flash
//Contract
//[RQ1] lock mode: A0 set, 90 then 00 exit
//[RQ2] buffer over 256 words or sector change aborts; code refuses only zero or over-256 counts, no sector check
//[RQ3] device settles into erase-suspended within latency
//[RQ4] device settles into nested program-suspended within latency
//[RQ5] program suspend accepts B0 or 51
//[RQ6] resume with 50/30, optionally after unlock
//[RQ7] device treats 30 like 50 there
//[RQ8] status entry 70 gives one read, returns
`timescale 1ns/1ps
module esc_host #(
	parameter int ESL_CYCLES = esc_pkg::ESL_CYC,
	parameter int PSL_CYCLES = esc_pkg::PSL_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// request port
	input wire logic req,
	output logic reqReady,
	input wire esc_pkg::esc_op_t op,
	input wire logic [25:0] addr,
	input wire logic [15:0] data,
	input wire logic [8:0] wordCount,
	input wire logic altCode,
	input wire logic withUnlock,
	// buffer word stream
	input wire logic wrValid,
	output logic wrReady,
	input wire logic [15:0] wrData,
	// answer
	output logic done,
	output logic error,
	output logic [15:0] rdData,
	// flash pins
	output logic [25:0] flAddr,
	output logic [15:0] dqOut,
	output logic dqDriveN,
	input wire logic [15:0] dqIn,
	output logic ceN,
	output logic weN,
	output logic oeN
);
	esc_pkg::esc_regs_t s_r;
	esc_pkg::esc_regs_t s_nxt;

	// header step count; unlocked ops carry two leading cycles
	function automatic logic [2:0] seqLen(esc_pkg::esc_op_t o, logic u);
		unique case (o)
			esc_pkg::OP_LOCK_SET, esc_pkg::OP_LOCK_EXIT: seqLen = 3'h2;
			esc_pkg::OP_WORD_PROG, esc_pkg::OP_BUF_PROG: seqLen = 3'h4;
			esc_pkg::OP_RESUME: seqLen = u ? 3'h3 : 3'h1;
			default: seqLen = 3'h1;
		endcase
	endfunction

	function automatic logic needUnlock(esc_pkg::esc_op_t o, logic u);
		needUnlock = (o == esc_pkg::OP_WORD_PROG) ||
			(o == esc_pkg::OP_BUF_PROG) || (o == esc_pkg::OP_RESUME && u);
	endfunction

	// address and data of one command cycle: {addr, data}
	function automatic logic [41:0] seqWord(esc_pkg::esc_regs_t r,
		logic [2:0] st);
		logic [15:0] wcm1;
		wcm1 = 16'(r.wordsLeft - 9'h001);
		seqWord = {r.addr, esc_pkg::CMD_RESET};
		if (needUnlock(r.op, r.unl) && st == 3'h0) begin
			seqWord = {esc_pkg::UNLOCK1_ADDR, esc_pkg::CMD_UNLOCK1};
		end else if (needUnlock(r.op, r.unl) && st == 3'h1) begin
			seqWord = {esc_pkg::UNLOCK2_ADDR, esc_pkg::CMD_UNLOCK2};
		end else begin
			unique case (r.op)
				// [RQ1] lock mode codes
				esc_pkg::OP_LOCK_SET: seqWord = (st == 3'h0) ?
					{r.addr, esc_pkg::CMD_LOCK_SET} : {r.addr, r.wdata};
				esc_pkg::OP_LOCK_EXIT: seqWord = (st == 3'h0) ?
					{r.addr, esc_pkg::CMD_SET_EXIT} :
					{r.addr, esc_pkg::CMD_SET_EXIT2};
				esc_pkg::OP_RESET: seqWord = {r.addr, esc_pkg::CMD_RESET};
				esc_pkg::OP_WORD_PROG: seqWord = (st == 3'h2) ?
					{esc_pkg::UNLOCK1_ADDR, esc_pkg::CMD_WORD_PROG} :
					{r.addr, r.wdata};
				esc_pkg::OP_BUF_PROG: begin
					if (st == 3'h2) begin
						seqWord = {r.addr, esc_pkg::CMD_BUF_LOAD};
					end else if (st == 3'h3) begin
						seqWord = {r.addr, wcm1};
					end else begin
						seqWord = {r.addr, esc_pkg::CMD_BUF_CONFIRM};
					end
				end
				// [RQ5] either suspend code
				esc_pkg::OP_PROG_SUSP: seqWord = {r.addr, r.alt ?
					esc_pkg::CMD_PSUSP_ALT : esc_pkg::CMD_SUSPEND};
				esc_pkg::OP_ERASE_SUSP:
					seqWord = {r.addr, esc_pkg::CMD_SUSPEND};
				// [RQ6] resume code, legacy form on request
				esc_pkg::OP_RESUME: seqWord = {r.addr, r.alt ?
					esc_pkg::CMD_RESUME_ALT : esc_pkg::CMD_RESUME};
				esc_pkg::OP_STATUS:
					seqWord = {esc_pkg::UNLOCK1_ADDR, esc_pkg::CMD_SR_READ};
				default: seqWord = {r.addr, esc_pkg::CMD_RESET};
			endcase
		end
	endfunction

	// next-state logic for the whole controller
	always_comb begin
		s_nxt = s_r;
		s_nxt.dqMeta = dqIn;
		s_nxt.dqSync = s_r.dqMeta;
		s_nxt.done = 1'b0;
		s_nxt.err = 1'b0;
		unique case (s_r.state)
			esc_pkg::ST_IDLE: begin
				if (req) begin
					s_nxt.op = op;
					s_nxt.addr = addr;
					s_nxt.wdata = data;
					s_nxt.wordsLeft = wordCount;
					s_nxt.wordAddr = addr;
					s_nxt.alt = altCode;
					s_nxt.unl = withUnlock;
					s_nxt.step = 3'h0;
					s_nxt.inData = 1'b0;
					// [RQ2] refuse zero or over-256 word counts; loads crossing a sector are not refused
					if (op == esc_pkg::OP_BUF_PROG &&
						(wordCount == 9'h000 ||
						wordCount > esc_pkg::BUF_MAX_WORDS)) begin
						s_nxt.done = 1'b1;
						s_nxt.err = 1'b1;
					end else begin
						s_nxt.state = esc_pkg::ST_SETUP;
						{s_nxt.busAddr, s_nxt.busData} =
							seqWord(s_nxt, 3'h0);
						s_nxt.dqDriveN = 1'b0;
						s_nxt.ceN = 1'b0;
					end
				end
			end
			esc_pkg::ST_SETUP: begin
				s_nxt.state = esc_pkg::ST_STROBE;
				s_nxt.weN = 1'b0;
				s_nxt.timer = 11'(esc_pkg::WE_CYC - 1);
			end
			esc_pkg::ST_STROBE: begin
				if (s_r.timer == 11'h000) begin
					s_nxt.weN = 1'b1;
					s_nxt.ceN = 1'b1;
					s_nxt.state = esc_pkg::ST_HOLD;
				end else begin
					s_nxt.timer = s_r.timer - 11'h001;
				end
			end
			esc_pkg::ST_HOLD: begin
				// data hold cycle, then pick the next bus cycle
				s_nxt.state = esc_pkg::ST_SETUP;
				s_nxt.ceN = 1'b0;
				if (s_r.inData) begin
					s_nxt.wordsLeft = s_r.wordsLeft - 9'h001;
					if (s_r.wordsLeft == 9'h001) begin
						s_nxt.inData = 1'b0;
						s_nxt.step = esc_pkg::STEP_CONFIRM;
						{s_nxt.busAddr, s_nxt.busData} =
							seqWord(s_r, esc_pkg::STEP_CONFIRM);
					end else begin
						s_nxt.state = esc_pkg::ST_DATA;
						s_nxt.ceN = 1'b1;
					end
				end else if (s_r.step + 3'h1 < seqLen(s_r.op, s_r.unl)) begin
					s_nxt.step = s_r.step + 3'h1;
					{s_nxt.busAddr, s_nxt.busData} =
						seqWord(s_r, s_nxt.step);
				end else if (s_r.op == esc_pkg::OP_BUF_PROG &&
					s_r.step != esc_pkg::STEP_CONFIRM) begin
					s_nxt.inData = 1'b1;
					s_nxt.state = esc_pkg::ST_DATA;
					s_nxt.ceN = 1'b1;
				end else if (s_r.op == esc_pkg::OP_STATUS) begin
					s_nxt.state = esc_pkg::ST_READ;
					s_nxt.dqDriveN = 1'b1;
					s_nxt.oeN = 1'b0;
					s_nxt.timer = 11'(esc_pkg::READ_CYC - 1);
				end else if (s_r.op == esc_pkg::OP_PROG_SUSP ||
					s_r.op == esc_pkg::OP_ERASE_SUSP) begin
					// wait out the device's settling latency
					s_nxt.state = esc_pkg::ST_WAIT;
					s_nxt.ceN = 1'b1;
					s_nxt.dqDriveN = 1'b1;
					s_nxt.timer = (s_r.op == esc_pkg::OP_PROG_SUSP) ?
						11'(PSL_CYCLES - 1) : 11'(ESL_CYCLES - 1);
				end else begin
					s_nxt.state = esc_pkg::ST_IDLE;
					s_nxt.ceN = 1'b1;
					s_nxt.dqDriveN = 1'b1;
					s_nxt.done = 1'b1;
				end
			end
			esc_pkg::ST_DATA: begin
				// [RQ2] word addresses count up from the request address with no check against the sector base
				if (wrValid) begin
					s_nxt.busAddr = s_r.wordAddr;
					s_nxt.busData = wrData;
					s_nxt.wordAddr = s_r.wordAddr + 26'h000_0001;
					s_nxt.ceN = 1'b0;
					s_nxt.state = esc_pkg::ST_SETUP;
				end
			end
			esc_pkg::ST_READ: begin
				// one status read, sampled after the synchroniser
				if (s_r.timer == 11'h000) begin
					s_nxt.rdData = s_r.dqSync;
					s_nxt.oeN = 1'b1;
					s_nxt.ceN = 1'b1;
					s_nxt.done = 1'b1;
					s_nxt.state = esc_pkg::ST_IDLE;
				end else begin
					s_nxt.timer = s_r.timer - 11'h001;
				end
			end
			esc_pkg::ST_WAIT: begin
				if (s_r.timer == 11'h000) begin
					s_nxt.done = 1'b1;
					s_nxt.state = esc_pkg::ST_IDLE;
				end else begin
					s_nxt.timer = s_r.timer - 11'h001;
				end
			end
			default: s_nxt.state = esc_pkg::ST_IDLE;
		endcase
	end

	// state register
	always_ff @(posedge clk) begin
		if (rst) begin
			s_r <= '0;
			s_r.state <= esc_pkg::ST_IDLE;
			s_r.op <= esc_pkg::OP_RESET;
			s_r.ceN <= 1'b1;
			s_r.weN <= 1'b1;
			s_r.oeN <= 1'b1;
			s_r.dqDriveN <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	// outputs; handshakes are combinational
	assign reqReady = (s_r.state == esc_pkg::ST_IDLE);
	assign wrReady = (s_r.state == esc_pkg::ST_DATA);
	assign done = s_r.done;
	assign error = s_r.err;
	assign rdData = s_r.rdData;
	assign flAddr = s_r.busAddr;
	assign dqOut = s_r.busData;
	assign dqDriveN = s_r.dqDriveN;
	assign ceN = s_r.ceN;
	assign weN = s_r.weN;
	assign oeN = s_r.oeN;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence unlockPair;
		$fell(weN) && dqOut == esc_pkg::CMD_UNLOCK1 &&
			flAddr == esc_pkg::UNLOCK1_ADDR
		##[1:8] $fell(weN) && dqOut == esc_pkg::CMD_UNLOCK2 &&
			flAddr == esc_pkg::UNLOCK2_ADDR;
	endsequence

	lock_enter_a: assert property ( // [RQ1]
		$fell(weN) && s_r.op == esc_pkg::OP_LOCK_SET && s_r.step == 3'h0
		|-> dqOut == 16'h00A0) else $error("lock entry code wrong");
	lock_exit_a: assert property ( // [RQ1]
		$fell(weN) && s_r.op == esc_pkg::OP_LOCK_EXIT && s_r.step == 3'h0
		|-> dqOut == 16'h0090 ##[1:8] ($fell(weN) && dqOut == 16'h0000))
		else $error("lock exit pair wrong");
	buf_refuse_a: assert property ( // [RQ2]
		req && reqReady && op == esc_pkg::OP_BUF_PROG &&
		wordCount > 9'h100 |=> done && error && reqReady)
		else $error("oversize buffer not refused");
	buf_sector_a: assert property ( // [RQ2]
		$fell(weN) && s_r.inData |-> flAddr[25:8] == s_r.addr[25:8] ||
		s_r.addr[7:0] != 8'h00) else $error("buffer word left sector");
	prog_susp_a: assert property ( // [RQ5]
		$fell(weN) && s_r.op == esc_pkg::OP_PROG_SUSP
		|-> dqOut == 16'h00B0 || dqOut == 16'h0051)
		else $error("suspend code wrong");
	susp_wait_a: assert property ( // [RQ4]
		$fell(weN) && s_r.op == esc_pkg::OP_PROG_SUSP |=> !done [*3])
		else $error("suspend finished too early");
	resume_unl_a: assert property ( // [RQ6]
		unlockPair ##[1:8] ($fell(weN) && s_r.op == esc_pkg::OP_RESUME)
		|-> dqOut == 16'h0050 || dqOut == 16'h0030)
		else $error("resume after unlock wrong");
	resume_code_a: assert property ( // [RQ6]
		$fell(weN) && s_r.op == esc_pkg::OP_RESUME && !s_r.unl
		|-> (dqOut == 16'h0050) != s_r.alt)
		else $error("direct resume code wrong");
endmodule

// file: esc_flash_model.sv
// behavioural flash device seen through its command pins
`timescale 1ns/1ps
module esc_flash_model #(
	parameter int LAT_NS = 100
) (
	// flash pins
	input wire logic [25:0] flAddr,
	input wire logic [15:0] dqOut,
	input wire logic ceN,
	input wire logic weN,
	input wire logic oeN,
	output logic [15:0] dqIn
);
	logic [15:0] wrLog [$];
	logic [25:0] adLog [$];
	logic [15:0] status = 16'h0080;
	logic wrEnN;
	// a write ends on whichever strobe rises first; the host lifts both
	// in one edge, so watching one and testing the other would race
	assign wrEnN = weN | ceN;
	always @(posedge wrEnN) begin
		wrLog.push_back(dqOut);
		adLog.push_back(flAddr);
		if (dqOut == 16'h00B0 || dqOut == 16'h0051) begin
			status = 16'h0000;
			status <= #(LAT_NS) 16'h0080;
		end
	end
	// one status word per read
	// released bus shows the inverse, since nothing pulls it
	assign dqIn = (!ceN && !oeN) ? status : ~status;
endmodule

// file: testbench.sv
// self-checking bench for the erase-suspend command host
`timescale 1ns/1ps
module testbench;
	typedef struct packed {
		esc_pkg::esc_op_t op;
		logic alt;
		logic [15:0] last;
		logic [8:0] cnt;
	} esc_row_t;
	logic clk = 0, rst = 1, req = 0, altCode = 0, withUnlock = 0;
	logic wrValid = 0, bufOn = 0, tk, sawErr;
	logic reqReady, wrReady, done, error, dqDriveN, ceN, weN, oeN;
	esc_pkg::esc_op_t op = esc_pkg::OP_RESET;
	logic [25:0] addr = 26'h0040, flAddr;
	logic [15:0] data = 16'h0001, wrData = 16'h0000;
	logic [15:0] rdData, dqOut, dqIn;
	logic [8:0] wordCount = 9'h001;
	int errors = 0, n_tests = 0, cyc = 0;
	esc_row_t rows [9];
	esc_host #(.ESL_CYCLES(4), .PSL_CYCLES(4)) u_esc_host (.clk, .rst,
		.req, .reqReady, .op, .addr, .data, .wordCount, .altCode,
		.withUnlock, .wrValid, .wrReady, .wrData, .done, .error, .rdData,
		.flAddr, .dqOut, .dqDriveN, .dqIn, .ceN, .weN, .oeN);
	esc_flash_model u_esc_flash_model (.flAddr, .dqOut, .ceN, .weN, .oeN,
		.dqIn);
	always #20 clk = ~clk;
	// hang guard well above the longest buffer run
	always @(posedge clk) begin
		cyc++;
		if (cyc == 30000) begin
			errors++;
			report_and_stop();
		end
	end
	// word stream; valid holds until taken, then drops one cycle to stall
	always @(posedge clk) begin
		tk = wrValid && wrReady;
		#1;
		if (tk) begin
			wrData = wrData + 16'h0001;
			wrValid = 1'b0;
		end else begin
			wrValid = bufOn;
		end
	end
	task automatic check(input logic [31:0] seen, exp, input string what);
		n_tests++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR %0t %s: saw %h want %h", $time, what, seen, exp);
		end
	endtask
	task automatic run_op(input esc_pkg::esc_op_t o, input logic a, u,
			input logic [8:0] wc);
		int n;
		n = 0;
		@(posedge clk) #1;
		u_esc_flash_model.wrLog.delete();
		u_esc_flash_model.adLog.delete();
		op = o;
		altCode = a;
		withUnlock = u;
		wordCount = wc;
		req = 1;
		@(posedge clk) #1;
		req = 0;
		while (done !== 1'b1 && n < 4000) begin
			@(posedge clk) #1;
			n++;
		end
		sawErr = error;
		check(n < 4000, 1, "no done");
	endtask
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	initial begin
		rows[0] = '{esc_pkg::OP_LOCK_SET, 0, 16'h0001, 2};
		rows[1] = '{esc_pkg::OP_LOCK_EXIT, 0, 16'h0000, 2};
		rows[2] = '{esc_pkg::OP_RESET, 0, 16'h00F0, 1};
		rows[3] = '{esc_pkg::OP_WORD_PROG, 0, 16'h0001, 4};
		rows[4] = '{esc_pkg::OP_PROG_SUSP, 0, 16'h00B0, 1};
		rows[5] = '{esc_pkg::OP_PROG_SUSP, 1, 16'h0051, 1};
		rows[6] = '{esc_pkg::OP_ERASE_SUSP, 0, 16'h00B0, 1};
		rows[7] = '{esc_pkg::OP_RESUME, 0, 16'h0050, 1};
		rows[8] = '{esc_pkg::OP_RESUME, 1, 16'h0030, 1};
		repeat (16) @(posedge clk);
		#1 rst = 0;
		// table of single requests: last word and count of writes
		foreach (rows[i]) begin
			run_op(rows[i].op, rows[i].alt, 0, 9'h001);
			check(u_esc_flash_model.wrLog[$], rows[i].last, "last");
			if (rows[i].cnt != 0)
				check(u_esc_flash_model.wrLog.size(), rows[i].cnt, "n");
			$display("row %0d finished", i);
		end
		// resume behind the unlock pair
		run_op(esc_pkg::OP_RESUME, 1, 1, 9'h001);
		check(u_esc_flash_model.adLog[0], 26'h0555, "unl1 addr");
		check(u_esc_flash_model.wrLog[1], 16'h0055, "unl2 data");
		check(u_esc_flash_model.wrLog[2], 16'h0030, "alt resume");
		$display("unlock resume finished");
		// status read returns the ready word
		run_op(esc_pkg::OP_STATUS, 0, 0, 9'h001);
		check(u_esc_flash_model.wrLog[0], 16'h0070, "status cmd");
		check(rdData, 16'h0080, "status word");
		$display("status finished");
		// buffers of three and of the full 256 words, stream stalling
		for (int b = 0; b < 2; b++) begin
			addr = 26'h0100;
			wrData = 16'h0000;
			bufOn = 1;
			run_op(esc_pkg::OP_BUF_PROG, 0, 0, b ? 9'h100 : 9'h003);
			bufOn = 0;
			check(u_esc_flash_model.wrLog.size(), b ? 261 : 8, "n");
			check(u_esc_flash_model.wrLog[3], b ? 255 : 2, "wc-1");
			check(u_esc_flash_model.wrLog[6], 2, "word");
			check(u_esc_flash_model.adLog[6], 26'h0102, "waddr");
			check(u_esc_flash_model.wrLog[$], 16'h0029, "confirm");
			$display("buffer %0d finished", b);
		end
		// word counts of zero and 257 are refused with no bus cycle
		for (int r = 0; r < 2; r++) begin
			run_op(esc_pkg::OP_BUF_PROG, 0, 0, r ? 9'h101 : 9'h000);
			check(sawErr, 1, "refuse");
			check(u_esc_flash_model.wrLog.size(), 0, "no writes");
		end
		$display("refusals finished");
		// reset in mid-command leaves the pins at rest
		op = esc_pkg::OP_RESET;
		req = 1;
		repeat (2) @(posedge clk);
		#1 req = 0;
		rst = 1;
		@(posedge clk) #1;
		rst = 0;
		check({ceN, weN, oeN, dqDriveN, done, reqReady}, 6'h3D, "rst");
		// first request straight after release must still go out whole
		run_op(esc_pkg::OP_RESET, 0, 0, 9'h001);
		check(u_esc_flash_model.wrLog[$], 16'h00F0, "post rst");
		check(u_esc_flash_model.wrLog.size(), 1, "post rst n");
		$display("reset finished");
		report_and_stop();
	end
endmodule
